// ### pkg/psbd_pkg.sv
// Constants, types and register map of the status-bit, bit-clear and
// decrement-and-branch execution block.
// Assumes byte-wide program memory and 9-bit data memory, both with one
// cycle of read latency on the CPU clock.
// Summary of operation
// - D9H/F9H, two bytes, write status bit 1
// - DBH/FBH, two bytes, write lookup bank bit 3
// - Bit clear zeroes one bit only
// - Short forms C8H/D8H, middle form D7H
// - Bit clear advances program counter 2 or 3
// - D7H form: 13-bit address, add three
// - 22H three bytes, bit0 selects form
// - Pointer register numbers 0 to 63 only
// - Plain form decrements byte at pointer
// - Nonzero result branches by 3 plus displacement
// - Zero result advances program counter by 3
// - Zero test uses low eight bits only
// - Ninth result bit copied to status bit 1
// - Missing ninth bit taken as one
// - C form adds C to pointer value
// - C register is signed eight bits
package psbd_pkg;

  localparam int PC_W = 17;
  localparam int DA_W = 16;
  localparam int DW_W = 9;

  // Opcodes and fixed operand values
  localparam logic [7:0] OPC_SET_BIT1  = 8'hF9;
  localparam logic [7:0] OPC_SET_BANK  = 8'hFB;
  localparam logic [7:0] CHG_SECOND    = 8'h06;
  localparam logic [4:0] CLR_LOW_HI5   = 5'h19;
  localparam logic [4:0] CLR_HIGH_HI5  = 5'h1B;
  localparam logic [7:0] OPC_CLR_MID   = 8'hD7;
  localparam logic [7:0] OPC_DEC_BR    = 8'h22;
  localparam logic [7:0] PAGE_LOW      = 8'h00;
  localparam logic [7:0] PAGE_HIGH     = 8'hFE;
  localparam int         SET_VAL_BIT   = 5;
  localparam int         CFORM_BIT     = 0;
  localparam int         OFFSET_BIT    = 7;

  // Instruction lengths
  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG  = 2'h3;

  // Status word
  localparam int               PSW_BIT1 = 1;
  localparam int               PSW_BANK = 3;
  localparam logic [7:0]       PSW_RST  = 8'h00;
  localparam logic [PC_W-1:0]  PC_RST   = 17'h00000;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC     = 8'h08;
  localparam logic [7:0] REG_PSW    = 8'h0C;
  localparam logic [7:0] REG_CREG   = 8'h10;
  localparam logic [7:0] REG_LASTOP = 8'h14;
  localparam int         CTRL_STEP  = 0;
  localparam int         CTRL_RUN   = 1;
  localparam int         STAT_BUSY  = 0;
  localparam int         STAT_ILL   = 1;

  typedef enum logic [1:0] {
    K_ILL  = 2'h0,
    K_PSW  = 2'h1,
    K_CLR  = 2'h2,
    K_DECBR = 2'h3
  } psbd_kind_e;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_F0   = 4'h1,
    S_F1   = 4'h2,
    S_F2   = 4'h3,
    S_F3   = 4'h4,
    S_EXE  = 4'h5,
    S_PLO  = 4'h6,
    S_PHI  = 4'h7,
    S_PTR  = 4'h8,
    S_TGT  = 4'h9,
    S_RD   = 4'hA,
    S_RDW  = 4'hB,
    S_WR   = 4'hC,
    S_DONE = 4'hD
  } psbd_state_e;

endpackage

// ### pkg/psbd_alu_if.sv
// Carrier between the sequencer and its decode/arithmetic unit.
// Assumes psbd_pkg is compiled first.
`timescale 1ns/1ps
interface psbd_alu_if;
  logic [7:0]                  op0;
  logic [7:0]                  op1;
  logic [7:0]                  op2;
  logic [psbd_pkg::PC_W-1:0]   pc;
  logic [7:0]                  creg;
  logic [psbd_pkg::DA_W-1:0]   ptr;
  logic [psbd_pkg::DW_W-1:0]   rdat;
  logic                        has8;
  psbd_pkg::psbd_kind_e        kind;
  logic [2:0]                  bitsel;
  logic                        setval;
  logic [1:0]                  len;
  logic [psbd_pkg::DA_W-1:0]   tgt;
  logic [psbd_pkg::DA_W-1:0]   ptr_addr;
  logic [psbd_pkg::PC_W-1:0]   pc_seq;
  logic [psbd_pkg::PC_W-1:0]   pc_br;
  logic [psbd_pkg::DW_W-1:0]   dec_res;
  logic [psbd_pkg::DW_W-1:0]   clr_res;
  logic                        dec_zero;

  modport core (output op0, op1, op2, pc, creg, ptr, rdat, has8,
                input  kind, bitsel, setval, len, tgt, ptr_addr, pc_seq, pc_br,
                       dec_res, clr_res, dec_zero);
  modport alu  (input  op0, op1, op2, pc, creg, ptr, rdat, has8,
                output kind, bitsel, setval, len, tgt, ptr_addr, pc_seq, pc_br,
                       dec_res, clr_res, dec_zero);
endinterface

// ### src/psbd_alu.sv
// Decode and arithmetic for the executed instruction group.
// Assumes the sequencer holds the three fetched bytes and read data stable.
`timescale 1ns/1ps
module psbd_alu (
  // Sequencer side
  psbd_alu_if.alu a
);
  import psbd_pkg::*;

  wire        chg_set   = (a.op0 == OPC_SET_BIT1) || (a.op0 == OPC_SET_BANK);
  wire        clr_low   = (a.op0[7:3] == CLR_LOW_HI5);
  wire        clr_high  = (a.op0[7:3] == CLR_HIGH_HI5);
  wire        clr_mid   = (a.op0 == OPC_CLR_MID);
  wire        is_psw    = (chg_set || clr_high) && (a.op1 == CHG_SECOND);
  wire        is_decbr  = (a.op0 == OPC_DEC_BR) && !a.op1[OFFSET_BIT];
  wire        cform     = a.op1[CFORM_BIT];
  wire [DW_W-1:0] val9  = a.has8 ? a.rdat : {1'b1, a.rdat[7:0]};
  wire [7:0]  bit_mask  = 8'h01 << a.bitsel;

  assign a.kind   = is_psw                        ? K_PSW  :
                    (clr_low || clr_high || clr_mid) ? K_CLR :
                    is_decbr                      ? K_DECBR : K_ILL;
  assign a.setval = a.op0[SET_VAL_BIT];
  assign a.bitsel = clr_mid ? a.op2[7:5] : a.op0[2:0];
  assign a.len    = (clr_mid || is_decbr) ? LEN_LONG : LEN_SHORT;
  assign a.tgt    = clr_mid  ? {3'h0, a.op2[4:0], a.op1} :
                    clr_high ? {PAGE_HIGH, a.op1} :
                    is_decbr ? a.ptr + (cform ? {{8{a.creg[7]}}, a.creg} : 16'h0000) :
                               {PAGE_LOW, a.op1};
  assign a.ptr_addr = {9'h000, a.op1[6:1], 1'b0};
  assign a.pc_seq   = a.pc + PC_W'(a.len);
  assign a.pc_br    = a.pc + PC_W'(LEN_LONG) + {{(PC_W-8){a.op2[7]}}, a.op2};
  assign a.dec_res  = val9 - 9'h001;
  assign a.dec_zero = (a.dec_res[7:0] == 8'h00);
  assign a.clr_res  = {a.rdat[8], a.rdat[7:0] & ~bit_mask};

endmodule

// ### src/psbd_exec.sv
// Execution sequencer with a classic Wishbone register slave.
// Assumes synchronous program and data memories on clk_i, one cycle of
// read latency, and dmem_has8_i valid with the read data.
`timescale 1ns/1ps
module psbd_exec #(
  parameter int ADR_W = 8
) (
  // Clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [ADR_W-1:0]              wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output      logic [31:0]                   wb_dat_o,
  output      logic                          wb_ack_o,
  // Program memory
  output      logic [psbd_pkg::PC_W-1:0]     prog_addr_o,
  output      logic                          prog_rd_o,
  input  wire logic [7:0]                    prog_data_i,
  // Data memory and special registers
  output      logic [psbd_pkg::DA_W-1:0]     dmem_addr_o,
  output      logic                          dmem_rd_o,
  output      logic                          dmem_wr_o,
  output      logic [psbd_pkg::DW_W-1:0]     dmem_wdata_o,
  input  wire logic [psbd_pkg::DW_W-1:0]     dmem_rdata_i,
  input  wire logic                          dmem_has8_i
);
  import psbd_pkg::*;

  psbd_state_e       st;
  logic [PC_W-1:0]   pc;
  logic [7:0]        psw;
  logic [7:0]        creg;
  logic [7:0]        op0;
  logic [7:0]        op1;
  logic [7:0]        op2;
  logic [DA_W-1:0]   ptr;
  logic [DW_W-1:0]   rdat_q;
  logic              has8_q;
  logic              run;
  logic              illegal;

  psbd_alu_if alu_bus ();

  psbd_alu u_alu (
    .a (alu_bus.alu)
  );

  assign alu_bus.op0  = op0;
  assign alu_bus.op1  = op1;
  assign alu_bus.op2  = op2;
  assign alu_bus.pc   = pc;
  assign alu_bus.creg = creg;
  assign alu_bus.ptr  = ptr;
  assign alu_bus.rdat = rdat_q;
  assign alu_bus.has8 = has8_q;

  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode
  wire [7:0]  reg_off  = {wb_adr_i[7:2], 2'h0};
  wire        bus_req  = wb_cyc_i && wb_stb_i;
  wire        bus_wr   = bus_req && wb_we_i && wb_ack_o;
  wire        hit_ctrl = (reg_off == REG_CTRL);
  wire        hit_stat = (reg_off == REG_STATUS);
  wire        hit_pc   = (reg_off == REG_PC);
  wire        hit_psw  = (reg_off == REG_PSW);
  wire        hit_creg = (reg_off == REG_CREG);
  wire        hit_last = (reg_off == REG_LASTOP);
  wire        idle     = (st == S_IDLE);
  wire [31:0] ctrl_new = wb_merge(32'h00000000, wb_dat_i, wb_sel_i);
  wire [31:0] pc_new   = wb_merge({15'h0000, pc}, wb_dat_i, wb_sel_i);
  wire [31:0] psw_new  = wb_merge({24'h000000, psw}, wb_dat_i, wb_sel_i);
  wire [31:0] creg_new = wb_merge({24'h000000, creg}, wb_dat_i, wb_sel_i);
  wire        step_req = bus_wr && hit_ctrl && ctrl_new[CTRL_STEP];
  wire        ill_evt  = (st == S_EXE) && (alu_bus.kind == K_ILL);
  wire        ill_clr  = bus_wr && hit_stat && ctrl_new[STAT_ILL];
  // Software may not move state under a running instruction
  wire        sw_pc    = bus_wr && hit_pc && idle;
  wire        sw_psw   = bus_wr && hit_psw && idle;
  wire        sw_creg  = bus_wr && hit_creg && idle;
  wire        go       = step_req || run;
  wire [31:0] rd_word  = hit_ctrl ? {30'h00000000, run, 1'b0} :
                         hit_stat ? {30'h00000000, illegal, !idle} :
                         hit_pc   ? {15'h0000, pc} :
                         hit_psw  ? {24'h000000, psw} :
                         hit_creg ? {24'h000000, creg} :
                         hit_last ? {8'h00, op0, op1, op2} : 32'h00000000;

  // Wishbone answer, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      wb_dat_o <= rd_word;
    end
  end

  // Run flag, illegal flag (set wins over clear), C register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run     <= 1'b0;
      illegal <= 1'b0;
      creg    <= 8'h00;
    end else begin
      if (ill_evt) begin
        run <= 1'b0;
      end else if (bus_wr && hit_ctrl && wb_sel_i[0]) begin
        run <= ctrl_new[CTRL_RUN];
      end
      if (ill_evt) begin
        illegal <= 1'b1;
      end else if (ill_clr) begin
        illegal <= 1'b0;
      end
      if (sw_creg) begin
        creg <= creg_new[7:0];
      end
    end
  end

  // Instruction sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st           <= S_IDLE;
      pc           <= PC_RST;
      psw          <= PSW_RST;
      op0          <= 8'h00;
      op1          <= 8'h00;
      op2          <= 8'h00;
      ptr          <= 16'h0000;
      rdat_q       <= 9'h000;
      has8_q       <= 1'b0;
      prog_addr_o  <= PC_RST;
      prog_rd_o    <= 1'b0;
      dmem_addr_o  <= 16'h0000;
      dmem_rd_o    <= 1'b0;
      dmem_wr_o    <= 1'b0;
      dmem_wdata_o <= 9'h000;
    end else begin
      unique case (st)
        S_IDLE: begin
          if (go) begin
            st          <= S_F0;
            prog_addr_o <= pc;
            prog_rd_o   <= 1'b1;
          end
          if (sw_pc) begin
            pc <= pc_new[PC_W-1:0];
          end
          if (sw_psw) begin
            psw <= psw_new[7:0];
          end
        end
        // Always fetch three bytes; the extra read is harmless
        S_F0: begin
          prog_addr_o <= pc + PC_W'(1);
          st          <= S_F1;
        end
        S_F1: begin
          op0         <= prog_data_i;
          prog_addr_o <= pc + PC_W'(LEN_SHORT);
          st          <= S_F2;
        end
        S_F2: begin
          op1       <= prog_data_i;
          prog_rd_o <= 1'b0;
          st        <= S_F3;
        end
        S_F3: begin
          op2 <= prog_data_i;
          st  <= S_EXE;
        end
        S_EXE: begin
          unique case (alu_bus.kind)
            K_PSW: begin
              psw[alu_bus.bitsel] <= alu_bus.setval;
              pc                  <= alu_bus.pc_seq;
              st                  <= S_DONE;
            end
            K_CLR: begin
              dmem_addr_o <= alu_bus.tgt;
              dmem_rd_o   <= 1'b1;
              st          <= S_RD;
            end
            K_DECBR: begin
              dmem_addr_o <= alu_bus.ptr_addr;
              dmem_rd_o   <= 1'b1;
              st          <= S_PLO;
            end
            K_ILL: begin
              st <= S_IDLE;
            end
          endcase
        end
        S_PLO: begin
          dmem_addr_o <= alu_bus.ptr_addr + 16'h0001;
          st          <= S_PHI;
        end
        S_PHI: begin
          ptr[7:0]  <= dmem_rdata_i[7:0];
          dmem_rd_o <= 1'b0;
          st        <= S_PTR;
        end
        S_PTR: begin
          ptr[15:8] <= dmem_rdata_i[7:0];
          st        <= S_TGT;
        end
        S_TGT: begin
          dmem_addr_o <= alu_bus.tgt;
          dmem_rd_o   <= 1'b1;
          st          <= S_RD;
        end
        S_RD: begin
          dmem_rd_o <= 1'b0;
          st        <= S_RDW;
        end
        S_RDW: begin
          rdat_q <= dmem_rdata_i;
          has8_q <= dmem_has8_i;
          st     <= S_WR;
        end
        S_WR: begin
          dmem_wr_o <= 1'b1;
          st        <= S_DONE;
          if (alu_bus.kind == K_DECBR) begin
            dmem_wdata_o    <= alu_bus.dec_res;
            psw[PSW_BIT1]   <= alu_bus.dec_res[8];
            pc <= alu_bus.dec_zero ? alu_bus.pc_seq : alu_bus.pc_br;
          end else begin
            dmem_wdata_o <= alu_bus.clr_res;
            pc           <= alu_bus.pc_seq;
          end
        end
        S_DONE: begin
          dmem_wr_o <= 1'b0;
          if (run) begin
            st          <= S_F0;
            prog_addr_o <= pc;
            prog_rd_o   <= 1'b1;
          end else begin
            st <= S_IDLE;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_chg_bit1;
    (st == S_EXE && alu_bus.kind == K_PSW && op0[2:0] == 3'h1)
      |=> (psw[PSW_BIT1] == $past(op0[SET_VAL_BIT])) && (pc == $past(pc) + 17'h00002);
  endproperty
  a_chg_bit1: assert property (p_chg_bit1) else $error("bit1 change wrong");

  property p_chg_bank;
    (st == S_EXE && alu_bus.kind == K_PSW && op0[2:0] == 3'h3)
      |=> (psw[PSW_BANK] == $past(op0[SET_VAL_BIT])) && $stable(psw[PSW_BIT1]);
  endproperty
  a_chg_bank: assert property (p_chg_bank) else $error("bank flag change wrong");

  property p_clr_one_bit;
    (st == S_WR && alu_bus.kind == K_CLR)
      |=> !dmem_wdata_o[alu_bus.bitsel]
          && ((dmem_wdata_o[7:0] | (8'h01 << alu_bus.bitsel))
              == (rdat_q[7:0] | (8'h01 << alu_bus.bitsel)));
  endproperty
  a_clr_one_bit: assert property (p_clr_one_bit) else $error("clear touched other bits");

  property p_clr_form;
    (st == S_EXE && alu_bus.kind == K_CLR)
      |-> (alu_bus.len == ((op0 == OPC_CLR_MID) ? 2'h3 : 2'h2))
          && ((op0 == OPC_CLR_MID) ? (alu_bus.tgt < 16'h2000) : (alu_bus.tgt[7:0] == op1));
  endproperty
  a_clr_form: assert property (p_clr_form) else $error("clear form decode wrong");

  property p_clr_pc;
    (st == S_EXE && alu_bus.kind == K_CLR) ##3 (st == S_WR)
      |=> pc == $past(pc, 4) + ((op0 == OPC_CLR_MID) ? 17'h00003 : 17'h00002);
  endproperty
  a_clr_pc: assert property (p_clr_pc) else $error("clear pc step wrong");

  property p_ptr_fetch;
    (st == S_EXE && alu_bus.kind == K_DECBR)
      |=> dmem_rd_o && dmem_addr_o == {9'h000, op1[6:1], 1'b0}
          ##1 dmem_addr_o == $past(dmem_addr_o) + 16'h0001;
  endproperty
  a_ptr_fetch: assert property (p_ptr_fetch) else $error("pointer word fetch wrong");

  property p_tgt_addr;
    (st == S_TGT)
      |=> dmem_rd_o && dmem_addr_o == $past(ptr) + (op1[0] ? {{8{creg[7]}}, creg} : 16'h0000);
  endproperty
  a_tgt_addr: assert property (p_tgt_addr) else $error("operand address wrong");

  property p_decbr_branch;
    (st == S_WR && alu_bus.kind == K_DECBR)
      |=> (dmem_wdata_o[7:0] == 8'h00)
            ? (pc == $past(pc) + 17'h00003)
            : (pc == $past(pc) + 17'h00003 + {{9{op2[7]}}, op2});
  endproperty
  a_decbr_branch: assert property (p_decbr_branch) else $error("branch target wrong");

  // Write strobe is a one-cycle pulse carrying the new flag
  property p_decbr_flag;
    (st == S_WR && alu_bus.kind == K_DECBR)
      |=> psw[PSW_BIT1] == dmem_wdata_o[8] && dmem_wr_o ##1 !dmem_wr_o;
  endproperty
  a_decbr_flag: assert property (p_decbr_flag) else $error("ninth bit not copied");

  property p_decbr_plain8;
    (st == S_WR && alu_bus.kind == K_DECBR && !has8_q && rdat_q[7:0] == 8'h00)
      |=> dmem_wdata_o == 9'h0FF && !psw[PSW_BIT1];
  endproperty
  a_decbr_plain8: assert property (p_decbr_plain8) else $error("8-bit wrap wrong");

  c_chg: cover property (st == S_EXE && alu_bus.kind == K_PSW);
  c_clr_mid: cover property (st == S_WR && alu_bus.kind == K_CLR && op0 == OPC_CLR_MID);
  c_decbr_taken: cover property (st == S_WR && alu_bus.kind == K_DECBR && !alu_bus.dec_zero);
  c_decbr_cform: cover property (st == S_TGT && op1[0]);

endmodule

// ### sim/psbd_mem_model.sv
// Behavioural program memory and data memory facing the execution block.
// Assumes one cycle of read latency on clk_i; the bench preloads the arrays.
`timescale 1ns/1ps
module psbd_mem_model (
  // Clock
  input  wire logic                      clk_i,
  // Program side
  input  wire logic [psbd_pkg::PC_W-1:0] prog_addr_i,
  input  wire logic                      prog_rd_i,
  output      logic [7:0]                prog_data_o,
  // Data side
  input  wire logic [psbd_pkg::DA_W-1:0] dmem_addr_i,
  input  wire logic                      dmem_rd_i,
  input  wire logic                      dmem_wr_i,
  input  wire logic [psbd_pkg::DW_W-1:0] dmem_wdata_i,
  output      logic [psbd_pkg::DW_W-1:0] dmem_rdata_o,
  output      logic                      dmem_has8_o
);
  import psbd_pkg::*;
  logic [7:0] prog [0:2047];
  logic [8:0] data [0:65535];
  logic       h8   [0:65535];
  initial begin
    prog_data_o = 8'h00;
    dmem_rdata_o = 9'h000;
    dmem_has8_o = 1'b0;
    for (int i = 0; i < 65536; i++) begin
      data[i] = 9'h000;
      h8[i] = 1'b0;
    end
  end
  // Idle read lines flip, so stale data never passes for an answer
  always @(posedge clk_i) begin
    prog_data_o <= prog_rd_i ? prog[prog_addr_i[10:0]] : ~prog_data_o;
    dmem_rdata_o <= dmem_rd_i ? data[dmem_addr_i] : ~dmem_rdata_o;
    dmem_has8_o <= dmem_rd_i ? h8[dmem_addr_i] : ~dmem_has8_o;
    // Byte locations keep no ninth bit
    if (dmem_wr_i) begin
      data[dmem_addr_i] <= {dmem_wdata_i[8] & h8[dmem_addr_i], dmem_wdata_i[7:0]};
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench: one instruction per table row, then awkward cases.
// Assumes psbd_pkg, the design and the memory model are compiled first.
`timescale 1ns/1ps
module tb_top;
  import psbd_pkg::*;
  typedef struct packed {
    logic [7:0]  b0, b1, b2;
    logic [11:0] pc0;
    logic [7:0]  psw0, c;
    logic [15:0] tad;
    logic [8:0]  tdin;
    logic        h8;
    logic [11:0] epc;
    logic [7:0]  epsw;
    logic [8:0]  etd;
  } psbd_row_s;
  logic        clk_i, rst_i, req, we_r, ack, prd, drd, dwr, dh8;
  logic [7:0]  adr, pdat;
  logic [31:0] wdat, rdat;
  logic [16:0] paddr;
  logic [15:0] daddr, p;
  logic [8:0]  dwd, drdat;
  logic [5:0]  n;
  psbd_row_s   rows[$];
  psbd_row_s   w;
  int          err_count, n_compared, cycles;

  psbd_exec #(.ADR_W(8)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we_r),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .prog_addr_o(paddr), .prog_rd_o(prd), .prog_data_i(pdat), .dmem_addr_o(daddr),
    .dmem_rd_o(drd), .dmem_wr_o(dwr), .dmem_wdata_o(dwd), .dmem_rdata_i(drdat),
    .dmem_has8_i(dh8));
  psbd_mem_model u_mem (
    .clk_i(clk_i), .prog_addr_i(paddr), .prog_rd_i(prd), .prog_data_o(pdat),
    .dmem_addr_i(daddr), .dmem_rd_i(drd), .dmem_wr_i(dwr), .dmem_wdata_i(dwd),
    .dmem_rdata_o(drdat), .dmem_has8_o(dh8));

  initial clk_i = 1'b0;
  always #25 clk_i = ~clk_i;

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hang counts as a mismatch
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    req <= 1'b1;
    we_r <= we;
    adr <= a;
    wdat <= d;
    // The acknowledge ends this wait; the cycle ceiling bounds it
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    req <= 1'b0;
    we_r <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(logic [7:0] a, logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask

  // Polls a register until the given bit drops; the cycle ceiling bounds it
  task automatic wait_low(logic [7:0] a, int b);
    logic [31:0] q;
    do begin
      wb(1'b0, a, 32'h00000000, q);
    end while (q[b] !== 1'b0);
  endtask

  function automatic void r(logic [7:0] b0, b1, b2, logic [11:0] pc0, logic [7:0] psw0, c,
                            logic [15:0] tad, logic [8:0] tdin, logic h8, logic [11:0] epc,
                            logic [7:0] epsw, logic [8:0] etd);
    rows.push_back('{b0, b1, b2, pc0, psw0, c, tad, tdin, h8, epc, epsw, etd});
  endfunction

  initial begin
    rst_i = 1'b1;
    req = 1'b0;
    we_r = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    r(8'hF9, 8'h06, 8'h00, 12'h100, 8'h00, 8'h00, 16'h0040, 9'h000, 1'b0, 12'h102, 8'h02, 9'h000);
    r(8'hD9, 8'h06, 8'h00, 12'h100, 8'hFF, 8'h00, 16'h0040, 9'h000, 1'b0, 12'h102, 8'hFD, 9'h000);
    r(8'hFB, 8'h06, 8'h00, 12'h100, 8'h00, 8'h00, 16'h0040, 9'h000, 1'b0, 12'h102, 8'h08, 9'h000);
    r(8'hDB, 8'h06, 8'h00, 12'h100, 8'hFF, 8'h00, 16'h0040, 9'h000, 1'b0, 12'h102, 8'hF7, 9'h000);
    r(8'hCD, 8'h10, 8'h00, 12'h100, 8'h00, 8'h00, 16'h0010, 9'h1FF, 1'b1, 12'h102, 8'h00, 9'h1DF);
    r(8'hDF, 8'h20, 8'h00, 12'h100, 8'h00, 8'h00, 16'hFE20, 9'h0FF, 1'b0, 12'h102, 8'h00, 9'h07F);
    r(8'hD7, 8'h34, 8'h52, 12'h100, 8'h00, 8'h00, 16'h1234, 9'h0FF, 1'b0, 12'h103, 8'h00, 9'h0FB);
    r(8'hD7, 8'hFF, 8'h1F, 12'h100, 8'h00, 8'h00, 16'h1FFF, 9'h001, 1'b0, 12'h103, 8'h00, 9'h000);
    r(8'h22, 8'h02, 8'h04, 12'h100, 8'h00, 8'h00, 16'h0055, 9'h101, 1'b1, 12'h103, 8'h02, 9'h100);
    r(8'h22, 8'h04, 8'h04, 12'h100, 8'hFF, 8'h00, 16'h0060, 9'h000, 1'b0, 12'h107, 8'hFD, 9'h0FF);
    r(8'h22, 8'h04, 8'hFC, 12'h200, 8'h02, 8'h00, 16'h0070, 9'h005, 1'b1, 12'h1FF, 8'h00, 9'h004);
    r(8'h22, 8'h7F, 8'h10, 12'h100, 8'h00, 8'hFC, 16'h02FC, 9'h003, 1'b0, 12'h113, 8'h02, 9'h002);
    r(8'h22, 8'h01, 8'h04, 12'h100, 8'h00, 8'h04, 16'h0059, 9'h001, 1'b0, 12'h103, 8'h02, 9'h000);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(REG_PC, 32'h00000000);
    rdchk(REG_PSW, 32'h00000000);
    rdchk(REG_STATUS, 32'h00000000);
    rdchk(8'h20, 32'h00000000);
    $display("test reset done");
    foreach (rows[i]) begin
      w = rows[i];
      u_mem.prog[w.pc0[10:0]] = w.b0;
      u_mem.prog[w.pc0[10:0] + 11'h001] = w.b1;
      u_mem.prog[w.pc0[10:0] + 11'h002] = w.b2;
      if (w.b0 == OPC_DEC_BR) begin
        n = w.b1[6:1];
        p = w.tad - (w.b1[0] ? {{8{w.c[7]}}, w.c} : 16'h0000);
        u_mem.data[{9'h000, n, 1'b0}] = {1'b0, p[7:0]};
        u_mem.data[{9'h000, n, 1'b1}] = {1'b0, p[15:8]};
      end
      u_mem.data[w.tad] = w.tdin;
      u_mem.h8[w.tad] = w.h8;
      wr(REG_PC, {20'h00000, w.pc0});
      wr(REG_PSW, {24'h000000, w.psw0});
      wr(REG_CREG, {24'h000000, w.c});
      wr(REG_CTRL, 32'h00000001);
      wait_low(REG_STATUS, STAT_BUSY);
      rdchk(REG_PC, {20'h00000, w.epc});
      rdchk(REG_PSW, {24'h000000, w.epsw});
      chk({23'h000000, u_mem.data[w.tad]}, {23'h000000, w.etd});
      $display("test row %0d done", i);
    end
    u_mem.prog[11'h300] = OPC_DEC_BR;
    u_mem.prog[11'h301] = 8'h80;
    u_mem.prog[11'h302] = 8'h00;
    wr(REG_PC, 32'h00000300);
    wr(REG_CTRL, 32'h00000001);
    wait_low(REG_STATUS, STAT_BUSY);
    rdchk(REG_STATUS, 32'h00000002);
    rdchk(REG_PC, 32'h00000300);
    wr(REG_STATUS, 32'h00000002);
    rdchk(REG_STATUS, 32'h00000000);
    $display("test illegal pointer done");
    u_mem.prog[11'h400] = OPC_SET_BANK;
    u_mem.prog[11'h401] = CHG_SECOND;
    u_mem.prog[11'h402] = OPC_DEC_BR;
    u_mem.prog[11'h403] = 8'h80;
    u_mem.prog[11'h404] = 8'h00;
    wr(REG_PSW, 32'h00000000);
    wr(REG_PC, 32'h00000400);
    wr(REG_CTRL, 32'h00000002);
    wait_low(REG_CTRL, CTRL_RUN);
    rdchk(REG_PC, 32'h00000402);
    rdchk(REG_PSW, 32'h00000008);
    rdchk(REG_LASTOP, 32'h00228000);
    $display("test run sequence done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(REG_PSW, 32'h00000000);
    rdchk(REG_STATUS, 32'h00000000);
    $display("test second reset done");
    final_report();
  end
endmodule
